/* File: logic/psie_pkg.sv */
// Package: register map, field layout, reset values and carrier types of the PHY status block
package psie_pkg;

  // Register indices as printed; the byte address is four times the index
  localparam logic [7:0] REG_IDX_STATUS = 8'h11;
  localparam logic [7:0] REG_IDX_MASK = 8'h12;
  localparam logic [7:0] REG_IDX_EVENTS = 8'h13;
  localparam logic [7:0] REG_IDX_CONFIG = 8'h14;
  localparam int PADDR_W = 8;
  localparam logic [7:0] ADDR_STATUS = 8'(REG_IDX_STATUS * 4);
  localparam logic [7:0] ADDR_MASK = 8'(REG_IDX_MASK * 4);
  localparam logic [7:0] ADDR_EVENTS = 8'(REG_IDX_EVENTS * 4);
  localparam logic [7:0] ADDR_CONFIG = 8'(REG_IDX_CONFIG * 4);

  // Status word field positions
  localparam int ST_SPEED_LSB = 14;
  localparam int ST_DUPLEX = 13;
  localparam int ST_PAGE = 12;
  localparam int ST_RESOLVED = 11;
  localparam int ST_LINK = 10;
  localparam int ST_XOVER_CD = 9;
  localparam int ST_XOVER_AB = 8;
  localparam int ST_GIG_MASKED = 7;
  localparam int ST_SLEEP = 6;
  localparam int ST_CHAN_POL_LSB = 2;
  localparam int ST_POL10 = 1;
  localparam int ST_JABBER = 0;

  // Speed encodings
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  // Event bit positions, shared by the enable word and the event status word
  localparam int EV_AN_ERROR = 15;
  localparam int EV_SPEED = 14;
  localparam int EV_DUPLEX = 13;
  localparam int EV_PAGE = 12;
  localparam int EV_AN_DONE = 11;
  localparam int EV_LINK = 10;
  localparam int EV_FALSE_CARRIER = 8;
  localparam int EV_XOVER = 6;
  localparam int EV_DOWNSHIFT = 5;
  localparam int EV_SLEEP = 4;
  localparam int EV_WAKE = 3;
  localparam int EV_MAC_IF_ERR = 2;
  localparam int EV_POLARITY = 1;
  localparam int EV_JABBER = 0;

  // Config word: interrupt pin polarity bit
  localparam int CFG_IRQ_ACTIVE_LOW = 13;

  // Reset values and writable / implemented bit masks
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] MASK_WR = 16'hFD7F;
  localparam logic [15:0] EVENTS_VALID = 16'hFD7F;
  localparam logic [15:0] CONFIG_RST = 16'h2000;
  localparam logic [15:0] CONFIG_WR = 16'h2000;

  // Live status from the transceiver core
  typedef struct packed {
    logic [1:0] speed;
    logic full_duplex;
    logic an_resolved;
    logic an_running;
    logic link_up;
    logic xover_cd;
    logic xover_ab;
    logic gig_masked;
    logic sleeping;
    logic [3:0] chan_pol_rev;
    logic pol10_ok;
    logic jabber;
  } psie_core_status_t;

  // Reset snapshot: 10 Mbps polarity reads correct, everything else zero
  localparam psie_core_status_t CORE_STATUS_RST = '{
    speed: SPEED_10, full_duplex: 1'b0, an_resolved: 1'b0, an_running: 1'b0,
    link_up: 1'b0, xover_cd: 1'b0, xover_ab: 1'b0, gig_masked: 1'b0,
    sleeping: 1'b0, chan_pol_rev: 4'h0, pol10_ok: 1'b1, jabber: 1'b0};

  // One-cycle event pulses from the transceiver core
  typedef struct packed {
    logic page_rx;
    logic an_error;
    logic false_carrier;
    logic wake_packet;
    logic mac_if_error;
  } psie_core_pulse_t;

endpackage

/* File: logic/psie_flag_latch.sv */
// Sticky flag bank: set by hardware, cleared as a whole by a read strobe
`timescale 1ns/1ps
module psie_flag_latch #(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] set_in,
  input wire logic clear_in,
  output logic [W-1:0] flags
);

  logic [W-1:0] state_reg;
  logic [W-1:0] state_next;

  // Set wins over clear so that an event in the clearing cycle survives
  always_comb
  begin
    state_next = set_in | (state_reg & ~{W{clear_in}});
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign flags = state_reg;

endmodule

/* File: logic/psie_regs.sv */
// PHY status word, interrupt enable word, event status and interrupt pin behind APB
//
// Notes on behaviour
// - Bits 15:14 show speed: 00 10M, 01 100M, 10 1000M, 11 reserved.
// - Bit 13 shows duplex: one full, zero half.
// - Bit 12 latches page received; reading the status word clears it.
// - Bit 11 set when negotiation done or disabled, else zero.
// - Bit 10 shows link up (one) or down (zero).
// - Bit 9 crossover of pairs C/D, bit 8 of pairs A/B; one crossed.
// - Bit 7 set while negotiating with gigabit abilities masked.
// - Bit 6 shows sleep (one) or active (zero).
// - Bits 5:2 per-channel polarity D..A, valid only linked at 1000M.
// - Bit 1 shows 10M polarity, one correct; resets to one.
// - Bit 0 mirrors jabber; reading the status word does not clear it.
// - An event interrupts only when its enable bit is set.
// - Enables at bits 15..10 for error, speed, duplex, page, done, link.
// - Enables false carrier 8, crossover 6, downshift 5, sleep 4; 9, 7 read zero.
// - Enables wake 3, MAC interface error 2, polarity 1, jabber 0; reset off.
// - Event flags set whenever the event occurs, enabled or not.
// - Event flags stay latched until the event word is read, which clears them.
// - Interrupt pin active low when config bit 13 is one, its default.
`timescale 1ns/1ps
module psie_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [psie_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire psie_pkg::psie_core_status_t core_status,
  input wire psie_pkg::psie_core_pulse_t core_pulse,
  output logic irq_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    psie_pkg::psie_core_status_t snap;
    logic [15:0] mask;
    logic [15:0] config_word;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic irq;
  } psie_state_t;

  localparam psie_state_t STATE_RST = '{
    snap: psie_pkg::CORE_STATUS_RST,
    mask: psie_pkg::MASK_RST,
    config_word: psie_pkg::CONFIG_RST,
    rdata: 32'h0000_0000,
    ready: 1'b0,
    slverr: 1'b0,
    irq: 1'b1};

  psie_state_t st_reg;
  psie_state_t st_next;

  logic [15:0] event_set;
  logic [15:0] event_flags;
  logic [0:0] page_flag;
  logic clear_status;
  logic clear_events;
  logic setup_phase;
  logic access_done;
  logic [15:0] status_word;

  ////////////////////////////////////////////////////////////////////////////
  // Bus phases

  // Setup is seen one cycle ahead so the answer comes with no wait state
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & st_reg.ready;

  // Read clears act at the decode edge, with the capture, so no event slips in between
  assign clear_status = setup_phase & ~pwrite & (paddr == psie_pkg::ADDR_STATUS);
  assign clear_events = setup_phase & ~pwrite & (paddr == psie_pkg::ADDR_EVENTS);

  ////////////////////////////////////////////////////////////////////////////
  // Event detection

  // Level changes compare the live core status with last cycle's snapshot
  always_comb
  begin
    event_set = 16'h0000;
    event_set[psie_pkg::EV_AN_ERROR] = core_pulse.an_error;
    event_set[psie_pkg::EV_SPEED] = core_status.speed != st_reg.snap.speed;
    event_set[psie_pkg::EV_DUPLEX] = core_status.full_duplex != st_reg.snap.full_duplex;
    event_set[psie_pkg::EV_PAGE] = core_pulse.page_rx;
    event_set[psie_pkg::EV_AN_DONE] = core_status.an_resolved & ~st_reg.snap.an_resolved;
    event_set[psie_pkg::EV_LINK] = core_status.link_up != st_reg.snap.link_up;
    event_set[psie_pkg::EV_FALSE_CARRIER] = core_pulse.false_carrier;
    event_set[psie_pkg::EV_XOVER] = (core_status.xover_cd != st_reg.snap.xover_cd)
      | (core_status.xover_ab != st_reg.snap.xover_ab);
    event_set[psie_pkg::EV_DOWNSHIFT] = core_status.gig_masked & ~st_reg.snap.gig_masked;
    event_set[psie_pkg::EV_SLEEP] = core_status.sleeping != st_reg.snap.sleeping;
    event_set[psie_pkg::EV_WAKE] = core_pulse.wake_packet;
    event_set[psie_pkg::EV_MAC_IF_ERR] = core_pulse.mac_if_error;
    event_set[psie_pkg::EV_POLARITY] = (core_status.pol10_ok != st_reg.snap.pol10_ok)
      | (core_status.chan_pol_rev != st_reg.snap.chan_pol_rev);
    event_set[psie_pkg::EV_JABBER] = core_status.jabber & ~st_reg.snap.jabber;
  end

  // Flags latch independent of the enables; reserved positions never set
  psie_flag_latch #(
    .W(16)
  ) u_event_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_in(event_set & psie_pkg::EVENTS_VALID),
    .clear_in(clear_events),
    .flags(event_flags)
  );

  // Page-received copy in the status word has its own clear-on-read
  psie_flag_latch #(
    .W(1)
  ) u_page_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set_in(core_pulse.page_rx),
    .clear_in(clear_status),
    .flags(page_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status word assembly

  // Built from the registered snapshot so a read sees one consistent cycle
  always_comb
  begin
    status_word = 16'h0000;
    status_word[psie_pkg::ST_SPEED_LSB +: 2] = st_reg.snap.speed;
    status_word[psie_pkg::ST_DUPLEX] = st_reg.snap.full_duplex;
    status_word[psie_pkg::ST_PAGE] = page_flag[0];
    status_word[psie_pkg::ST_RESOLVED] = st_reg.snap.an_resolved;
    status_word[psie_pkg::ST_LINK] = st_reg.snap.link_up;
    status_word[psie_pkg::ST_XOVER_CD] = st_reg.snap.xover_cd;
    status_word[psie_pkg::ST_XOVER_AB] = st_reg.snap.xover_ab;
    // Masking only means something while negotiation runs
    status_word[psie_pkg::ST_GIG_MASKED] = st_reg.snap.gig_masked
      & st_reg.snap.an_running;
    status_word[psie_pkg::ST_SLEEP] = st_reg.snap.sleeping;
    // Channel polarity is forced to normal unless linked at gigabit speed
    if (st_reg.snap.link_up && (st_reg.snap.speed == psie_pkg::SPEED_1000))
    begin
      status_word[psie_pkg::ST_CHAN_POL_LSB +: 4] = st_reg.snap.chan_pol_rev;
    end
    status_word[psie_pkg::ST_POL10] = st_reg.snap.pol10_ok;
    status_word[psie_pkg::ST_JABBER] = st_reg.snap.jabber;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    st_next = st_reg;
    st_next.snap = core_status;
    st_next.ready = setup_phase;
    st_next.slverr = 1'b0;
    st_next.rdata = 32'h0000_0000;

    // Decode at setup; read data and error stand through the access phase
    if (setup_phase)
    begin
      case (paddr)
        psie_pkg::ADDR_STATUS:
        begin
          if (!pwrite)
            st_next.rdata = {16'h0000, status_word};
        end
        psie_pkg::ADDR_MASK:
        begin
          if (!pwrite)
            st_next.rdata = {16'h0000, st_reg.mask};
        end
        psie_pkg::ADDR_EVENTS:
        begin
          if (!pwrite)
            st_next.rdata = {16'h0000, event_flags};
        end
        psie_pkg::ADDR_CONFIG:
        begin
          if (!pwrite)
            st_next.rdata = {16'h0000, st_reg.config_word};
        end
        default:
        begin
          st_next.slverr = 1'b1; // Unmapped address answers with an error
        end
      endcase
    end

    // Writes land at the completing edge; read-only words drop them
    if (access_done && pwrite)
    begin
      case (paddr)
        psie_pkg::ADDR_MASK:
        begin
          st_next.mask = pwdata[15:0] & psie_pkg::MASK_WR;
        end
        psie_pkg::ADDR_CONFIG:
        begin
          st_next.config_word = pwdata[15:0] & psie_pkg::CONFIG_WR;
        end
        default:
        begin
          st_next.mask = st_reg.mask; // Status and event words ignore writes
        end
      endcase
    end

    // Pin level: asserted while any enabled flag is pending, inverted if active low
    st_next.irq = (|(event_flags & st_reg.mask))
      ^ st_reg.config_word[psie_pkg::CFG_IRQ_ACTIVE_LOW];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Reset loads constants only; the snapshot catches up on the first edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= STATE_RST;
    else
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // All outputs come straight from the state register
  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.slverr;
  assign irq_pin = st_reg.irq;

endmodule

/* File: dv/psie_host.sv */
// Host model: APB master issuing one transfer per call
`timescale 1ns/1ps
module psie_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Entered just after a rising edge; waits for pready, only the watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never drives psel twice in one time step
    @(posedge pclk);
  endtask
endmodule

/* File: dv/psie_regs_chk.sv */
// Checker: bus timing, errors, readback and interrupt pin relations
`timescale 1ns/1ps
module psie_regs_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [psie_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire psie_pkg::psie_core_status_t core_status,
  input wire psie_pkg::psie_core_pulse_t core_pulse,
  input wire logic irq_pin
);
  logic [15:0] mask_reg;
  logic pol_reg;
  logic wr_done;
  logic mapped;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Shadow of the writable words; only the completing edge counts
  assign wr_done = psel && penable && pready && pwrite;
  assign mapped = paddr inside {psie_pkg::ADDR_STATUS, psie_pkg::ADDR_MASK,
                                psie_pkg::ADDR_EVENTS, psie_pkg::ADDR_CONFIG};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_reg <= psie_pkg::MASK_RST;
      pol_reg <= 1'b1;
    end
    else if (wr_done && paddr == psie_pkg::ADDR_MASK)
      mask_reg <= pwdata[15:0] & psie_pkg::MASK_WR;
    else if (wr_done && paddr == psie_pkg::ADDR_CONFIG)
      pol_reg <= pwdata[13];
  end

  ////////////////////////////////////////////////////////////////////////
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_ERR_UNMAPPED: assert property (psel && !penable && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_NOERR_MAPPED: assert property (psel && !penable && mapped |=> !pslverr)
    else $error("mapped access refused");
  AST_UPPER_ZERO: assert property (prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_MASK_RESV: assert property (pready && paddr == psie_pkg::ADDR_MASK |-> !prdata[9] && !prdata[7])
    else $error("reserved enable bit reads one");
  AST_MASK_READBACK: assert property (pready && !pwrite && paddr == psie_pkg::ADDR_MASK |-> prdata[15:0] == mask_reg)
    else $error("enable word readback wrong");
  AST_IRQ_MASKED: assert property ((mask_reg == 16'h0000 && $stable(pol_reg)) [*2] |-> irq_pin == pol_reg)
    else $error("interrupt active with all enables off");
  AST_IRQ_EVENT: assert property (core_pulse.false_carrier && mask_reg[8] && pol_reg |-> ##2 !irq_pin)
    else $error("enabled event did not interrupt");
  COV_ERR: cover property (pslverr);
  COV_IRQ: cover property (mask_reg != 16'h0000 ##1 irq_pin != pol_reg);
  COV_WR: cover property (wr_done && paddr == psie_pkg::ADDR_MASK);
endmodule

bind psie_regs psie_regs_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .core_status(core_status), .core_pulse(core_pulse),
  .irq_pin(irq_pin));

/* File: dv/tb_top.sv */
// Testbench: status word, enables, event flags and interrupt pin scenarios
`timescale 1ns/1ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_pin;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  psie_pkg::psie_core_status_t core_status;
  psie_pkg::psie_core_pulse_t core_pulse;
  int miscompares = 0;
  int n_tests = 0;

  psie_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  psie_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_status(core_status), .core_pulse(core_pulse), .irq_pin(irq_pin));

  // 10 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, q, e);
    check(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic pulse(input psie_pkg::psie_core_pulse_t p);
    core_pulse <= p;
    @(posedge pclk);
    core_pulse <= '0;
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(posedge pclk);
    check({31'h0, irq_pin}, {31'h0, v});
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(psie_pkg::ADDR_MASK, 32'h0);
    rdc(psie_pkg::ADDR_STATUS, 32'h2);
    rdc(psie_pkg::ADDR_CONFIG, 32'h2000);
    check({31'h0, irq_pin}, 32'h1);
  endtask
  // Two core snapshots; the second also checks that writes and reads leave it alone
  task automatic t_status;
    core_status <= '{speed: psie_pkg::SPEED_1000, full_duplex: 1'b1, an_resolved: 1'b1,
      an_running: 1'b0, link_up: 1'b1, xover_cd: 1'b1, xover_ab: 1'b0, gig_masked: 1'b0,
      sleeping: 1'b0, chan_pol_rev: 4'hA, pol10_ok: 1'b1, jabber: 1'b0};
    repeat (2) @(posedge pclk);
    rdc(psie_pkg::ADDR_STATUS, 32'hAE2A);
    rdc(psie_pkg::ADDR_EVENTS, 32'h6C42);
    rdc(psie_pkg::ADDR_EVENTS, 32'h0);
    core_status <= '{speed: psie_pkg::SPEED_100, full_duplex: 1'b0, an_resolved: 1'b0,
      an_running: 1'b1, link_up: 1'b1, xover_cd: 1'b0, xover_ab: 1'b1, gig_masked: 1'b1,
      sleeping: 1'b1, chan_pol_rev: 4'hF, pol10_ok: 1'b0, jabber: 1'b1};
    wr(psie_pkg::ADDR_STATUS, 32'hFFFF);
    rdc(psie_pkg::ADDR_STATUS, 32'h45C1);
    rdc(psie_pkg::ADDR_STATUS, 32'h45C1);
  endtask
  task automatic t_page;
    pulse('{page_rx: 1'b1, wake_packet: 1'b1, mac_if_error: 1'b1, default: 1'b0});
    rdc(psie_pkg::ADDR_STATUS, 32'h55C1);
    rdc(psie_pkg::ADDR_STATUS, 32'h45C1);
    rdc(psie_pkg::ADDR_EVENTS, 32'h707F);
  endtask
  task automatic t_mask;
    wr(psie_pkg::ADDR_MASK, 32'hFFFF);
    rdc(psie_pkg::ADDR_MASK, 32'hFD7F);
    wr(psie_pkg::ADDR_MASK, 32'h0);
    rdc(psie_pkg::ADDR_MASK, 32'h0);
  endtask
  // Flag without enable stays quiet; then enabled, cleared, and polarity flipped
  task automatic t_irq;
    pulse('{false_carrier: 1'b1, default: 1'b0});
    irq_is(1'b1);
    rdc(psie_pkg::ADDR_EVENTS, 32'h0100);
    wr(psie_pkg::ADDR_MASK, 32'h0100);
    pulse('{false_carrier: 1'b1, default: 1'b0});
    irq_is(1'b0);
    rdc(psie_pkg::ADDR_EVENTS, 32'h0100);
    irq_is(1'b1);
    wr(psie_pkg::ADDR_CONFIG, 32'h0);
    irq_is(1'b0);
    wr(psie_pkg::ADDR_MASK, 32'h8000);
    pulse('{an_error: 1'b1, default: 1'b0});
    irq_is(1'b1);
    rdc(psie_pkg::ADDR_EVENTS, 32'h8000);
  endtask
  task automatic t_err;
    host.xfer(1'b0, 8'h54, 32'h0, q, e);
    check({q[30:0], e}, 32'h1);
    wr(psie_pkg::ADDR_EVENTS, 32'hFFFF);
    rdc(psie_pkg::ADDR_EVENTS, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    core_status = psie_pkg::CORE_STATUS_RST;
    core_pulse = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_status;
    t_page;
    t_mask;
    t_irq;
    t_err;
    results;
  end
  // Watchdog, well beyond the hundred or so cycles the run needs
  initial
  begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    results;
  end
endmodule
